// ---- verilog/srs_pkg.sv ----
// constants shared by the spi register access slave
package srs_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam logic [4:0] HEAD_LAST = 5'h07;
  localparam logic [4:0] DATA_FIRST = 5'h08;
  localparam logic [4:0] BLOCK_LAST = 5'h0F;
  localparam logic [0:0] DIR_WRITE = 1'h0;
  localparam logic [0:0] DIR_READ = 1'h1;
  // header bits sit here after seven shifts, the eighth still on the pin
  localparam int DIR_POS = 6;
  localparam int STEP_POS = 5;
  localparam logic [5:0] ADDR_RST = 6'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;
endpackage

// ---- verilog/srs_spi_register_access_slave.sv ----
// spi register access slave with sampled port clock, 3/4 wire modes
// What this block does
// - drive on falling, sample on rising edge
// - frames are 16 pulses plus 8-pulse blocks
// - bit 0 starts first falling after select
// - bit 0: 0 write, 1 read
// - drive output from start of bit 8
// - bit 1 steps index per block
// - bits 2 to 7 hold register index
// - read byte returned msb first, then more
// - each extra block moves one byte
// - three-wire select bit sets three-wire mode
// - three-wire read keeps the same layout
// - select high means i2c, spi idle
// - three-wire reads drive serial input line
`timescale 1ns/100ps
// timing walk, in mclk cycles after a port clock edge:
//   edge reaches the second sync flop after two cycles
//   edge detect flags it in that same cycle
//   header decode and read strobe follow one cycle later
//   read byte loads the shift register on the next cycle
//   first read bit leaves about three cycles after the falling edge
// trade-off: oversampling keeps one clock domain at the cost of a
// port clock limit near mclk / 8
module srs_spi_register_access_slave (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // spi pins
  input wire logic portSelect_n,
  input wire logic portClock,
  input wire logic serialInLine_i,
  output logic serialInLine_o,
  output logic serialInLine_oe_n,
  output logic serialOutLine,
  output logic serialOutLine_oe_n,
  // mode from second control register
  input wire logic threeWireSelect,
  // register file side
  output logic [srs_pkg::ADDR_W-1:0] regIndex,
  output logic [srs_pkg::DATA_W-1:0] writeByte,
  output logic writeStrobe,
  input wire logic [srs_pkg::DATA_W-1:0] readByte,
  output logic readStrobe,
  output logic frameActive
);

  // frame phases:
  //   idle  - select high or just after reset, nothing counted
  //   head  - direction, step flag and index coming in
  //   wdata - write blocks, one strobe per received byte
  //   rdata - read blocks, one prefetch strobe per byte
  typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_WDATA, ST_RDATA} srs_state_t;

  // all state in one record so reset and next value stay in step
  // sync stages: bit 0 first flop, bit 1 second, bit 2 edge history
  // bitCnt counts bits of the current header or block, 0 to 7
  // started marks that the falling edge of bit 0 has been seen
  typedef struct packed {
    logic [2:0] csSync;
    logic [2:0] clkSync;
    logic [2:0] sdiSync;
    srs_state_t state;
    logic [srs_pkg::CNT_W-1:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic stepOn;
    logic [srs_pkg::ADDR_W-1:0] index;
    logic [srs_pkg::DATA_W-1:0] wByte;
    logic wStb;
    logic rStb;
    logic driving;
    logic dout;
    logic started;
  } srs_regs_t;

  // registered state and its next value; decoded pin views below
  // are plain wires so edges cost no extra cycle
  // of latency beyond the synchroniser itself
  // (clock edges and select are both seen at the second stage)
  srs_regs_t st_r;
  srs_regs_t st_nxt;
  logic selLow;
  logic clkRise;
  logic clkFall;
  logic sdiBit;

  // second stage onward only; stage 0 feeds stage 1 alone
  assign selLow = ~st_r.csSync[1];
  assign clkRise = st_r.clkSync[1] & ~st_r.clkSync[2];
  assign clkFall = ~st_r.clkSync[1] & st_r.clkSync[2];
  // in three-wire mode the input pad also carries the return bits
  assign sdiBit = st_r.sdiSync[1];

  // limitation: the port clock must stay below about an eighth of
  // mclk, since each edge needs two mclk cycles to be seen
  // abort on select high wins over all frame logic except the post-strobe index step and shiftOut load
  // next-state logic for the whole frame engine
  always_comb begin
    st_nxt = st_r;
    st_nxt.csSync = {st_r.csSync[1:0], portSelect_n};
    st_nxt.clkSync = {st_r.clkSync[1:0], portClock};
    st_nxt.sdiSync = {st_r.sdiSync[1:0], serialInLine_i};
    st_nxt.wStb = 1'b0;
    st_nxt.rStb = 1'b0;
    if (!selLow) begin
      // select high: i2c personality, frame aborted
      st_nxt.state = ST_IDLE;
      st_nxt.bitCnt = '0;
      st_nxt.driving = 1'b0;
      st_nxt.started = 1'b0;
    end else begin
      if (st_r.state == ST_IDLE) begin
        st_nxt.state = ST_HEAD;
        // stale bits from an aborted frame must not leak into the header
        st_nxt.shiftIn = srs_pkg::BYTE_RST;
        st_nxt.bitCnt = '0;
        st_nxt.started = 1'b0;
      end
      // a bit begins on each falling edge; first one is bit 0
      if (clkFall && st_r.state != ST_IDLE) begin
        if (!st_r.started) begin
          st_nxt.started = 1'b1;
        end else begin
          st_nxt.bitCnt = st_r.bitCnt + 5'h01;
        end
        if (st_r.state == ST_RDATA) begin
          // shift out msb first at bit start
          st_nxt.dout = st_r.shiftOut[7];
          st_nxt.shiftOut = {st_r.shiftOut[6:0], 1'b0};
          st_nxt.driving = 1'b1;
        end
      end
      if (clkRise && st_r.started) begin
        st_nxt.shiftIn = {st_r.shiftIn[6:0], sdiBit};
        unique case (st_r.state)
          ST_HEAD: begin
            if (st_r.bitCnt == srs_pkg::HEAD_LAST) begin
              st_nxt.stepOn = st_r.shiftIn[srs_pkg::STEP_POS];
              st_nxt.index = {st_r.shiftIn[4:0], sdiBit};
              st_nxt.bitCnt = '0;
              st_nxt.started = 1'b0;
              if (st_r.shiftIn[srs_pkg::DIR_POS] == srs_pkg::DIR_READ) begin
                st_nxt.state = ST_RDATA;
                st_nxt.rStb = 1'b1;
              end else begin
                st_nxt.state = ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (st_r.bitCnt[2:0] == 3'h7) begin
              st_nxt.wByte = {st_r.shiftIn[6:0], sdiBit};
              st_nxt.wStb = 1'b1;
            end
          end
          ST_RDATA: begin
            if (st_r.bitCnt[2:0] == 3'h7) begin
              st_nxt.rStb = 1'b1;
            end
          end
          ST_IDLE: begin
            // nothing counts before the frame opens
          end
        endcase
      end
      // counter restarts each data block; bit 0 of block re-arms
      if (clkRise && st_r.started && st_r.state != ST_HEAD
          && st_r.bitCnt[2:0] == 3'h7) begin
        st_nxt.bitCnt = '0;
        st_nxt.started = 1'b0;
      end
    end
    // stepping after the strobe keeps regIndex steady while the
    // outer register file stores or reads the byte; the index
    // wraps from 63 to 0 when stepping past the top
    // index steps after the byte strobe has been served
    if (st_r.wStb && st_r.stepOn) begin
      st_nxt.index = st_r.index + 6'h01;
    end
    if (st_r.rStb) begin
      st_nxt.shiftOut = readByte;
      if (st_r.state == ST_RDATA && st_r.stepOn) begin
        st_nxt.index = st_r.index + 6'h01;
      end
    end
  end

  // sync reset; select and clock stages start high so no false
  // edge or frame shows up on the first cycles after release
  // single register bank for all state
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_r <= '{csSync: srs_pkg::SYNC_RST, clkSync: srs_pkg::SYNC_RST,
                sdiSync: 3'h0, state: ST_IDLE, bitCnt: '0,
                shiftIn: srs_pkg::BYTE_RST, shiftOut: srs_pkg::BYTE_RST,
                stepOn: 1'b0, index: srs_pkg::ADDR_RST, wByte: srs_pkg::BYTE_RST,
                wStb: 1'b0, rStb: 1'b0, driving: 1'b0, dout: 1'b0,
                started: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // data pins come straight from flops; only the enables mix in the
  // mode level, which is static between frames
  // both pads stay released for writes and during the header
  // pad steering between four- and three-wire modes
  assign serialOutLine = st_r.dout;
  assign serialOutLine_oe_n = ~(st_r.driving & ~threeWireSelect);
  assign serialInLine_o = st_r.dout;
  assign serialInLine_oe_n = ~(st_r.driving & threeWireSelect);
  assign regIndex = st_r.index;
  assign writeByte = st_r.wByte;
  assign writeStrobe = st_r.wStb;
  assign readStrobe = st_r.rStb;
  assign frameActive = st_r.state != ST_IDLE;

endmodule // srs_spi_register_access_slave

// ---- testbench/srs_properties.sv ----
// port checks for the spi register access slave
`timescale 1ns/100ps
module srs_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // watched ports
  input wire logic portSelect_n,
  input wire logic threeWireSelect,
  input wire logic serialInLine_oe_n,
  input wire logic serialOutLine_oe_n,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic frameActive
);
  // one domain; six idle cycles cover the select synchroniser delay
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wr_pulse_a: assert property (writeStrobe |=> !writeStrobe) else $error("wr pulse");
  rd_pulse_a: assert property (readStrobe |=> !readStrobe) else $error("rd pulse");
  dir_excl_a: assert property (!(writeStrobe && readStrobe)) else $error("both");
  out_pin_a: assert property (threeWireSelect |-> serialOutLine_oe_n) else $error("out");
  in_pad_a: assert property (!threeWireSelect |-> serialInLine_oe_n) else $error("in");
  idle_release_a: assert property (portSelect_n [*6] |-> !frameActive &&
    serialOutLine_oe_n && serialInLine_oe_n) else $error("held");
  idle_quiet_a: assert property (portSelect_n [*6] |-> !writeStrobe && !readStrobe)
    else $error("idle strobe");
  frame_open_a: assert property ($fell(portSelect_n) ##1 !portSelect_n [*5]
    |-> frameActive) else $error("no frame");
  cover property (writeStrobe);
  cover property (readStrobe && threeWireSelect);
  cover property (!serialOutLine_oe_n);
endmodule // srs_properties
bind srs_spi_register_access_slave srs_properties u_srs_properties (.mclk(mclk),
  .reset_n(reset_n), .portSelect_n(portSelect_n), .threeWireSelect(threeWireSelect),
  .serialInLine_oe_n(serialInLine_oe_n), .serialOutLine_oe_n(serialOutLine_oe_n),
  .writeStrobe(writeStrobe), .readStrobe(readStrobe), .frameActive(frameActive));

// ---- testbench/srs_master_model.sv ----
// spi master model with a 400 ns port clock
`timescale 1ns/100ps
module srs_master_model (
  // pins toward the slave
  output logic portSelect_n = 1'b1,
  output logic portClock = 1'b1,
  output logic dataOut = 1'b0,
  output logic dataEn = 1'b1,
  input wire logic dataIn
);
  // one frame: header then nb blocks, msb first
  task automatic frame(input logic [7:0] hdr, input int nb, input logic [31:0] wd,
    output logic [31:0] rd);
    logic [39:0] sh = {hdr, wd};
    portSelect_n = 1'b0;
    #300;
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      portClock = 1'b0;
      dataOut = sh[39 - i];
      dataEn = !(hdr[7] && i > 7);
      #200 portClock = 1'b1;
      rd = {rd[30:0], dataIn};
      #200;
    end
    #200 portSelect_n = 1'b1;
    dataEn = 1'b1;
    #1000;
  endtask
endmodule // srs_master_model

// ---- testbench/spi_register_access_slave_test.sv ----
// corner and random frames against the spi register access slave
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module spi_register_access_slave_test;
  logic mclk = 1'b0, reset_n = 1'b0, threeWireSelect = 1'b0;
  logic portSelect_n, portClock, mOut, mEn, pad, rdLine, inO, inOeN, outLine, outOeN;
  logic writeStrobe, readStrobe, dir, step;
  logic [5:0] regIndex;
  logic [7:0] writeByte, readByte, mem [64], shadow [64];
  logic [31:0] wd, rd;
  int num_errors = 0, tests_run = 0, nb, idx;
  // clock; an undriven line toggles so a stale bit never passes
  always #25 mclk = ~mclk;
  assign pad = !inOeN ? inO : mEn ? mOut : mclk;
  assign rdLine = threeWireSelect ? pad : outOeN ? mclk : outLine;
  assign readByte = mem[regIndex];
  // register file behind the strobes
  always @(posedge mclk) if (writeStrobe) mem[regIndex] <= writeByte;
  srs_spi_register_access_slave u_srs_spi_register_access_slave (.mclk(mclk),
    .reset_n(reset_n), .portSelect_n(portSelect_n), .portClock(portClock),
    .serialInLine_i(pad), .serialInLine_o(inO), .serialInLine_oe_n(inOeN),
    .serialOutLine(outLine), .serialOutLine_oe_n(outOeN), .threeWireSelect(threeWireSelect),
    .regIndex(regIndex), .writeByte(writeByte), .writeStrobe(writeStrobe),
    .readByte(readByte), .readStrobe(readStrobe), .frameActive());
  srs_master_model u_srs_master_model (.portSelect_n(portSelect_n), .portClock(portClock),
    .dataOut(mOut), .dataEn(mEn), .dataIn(rdLine));
  // index of block k
  function automatic int addr_of(int b, bit s, int k); return b + (s ? k : 0); endfunction
  // verdict
  task automatic close_out();
    $display("%0d errors in %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // corners at index 63 and 0 first, then random frames
  initial begin
    void'($urandom(32'h9810));
    foreach (mem[i]) begin
      mem[i] = $urandom;
      shadow[i] = mem[i];
    end
    repeat (10) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    for (int t = 0; t < 24; t++) begin
      dir = t < 4 ? t[0] : 1'($urandom);
      step = t < 4 ? t[1] : 1'($urandom);
      nb = t < 4 ? 2 + t[1] : 1 + $urandom_range(2);
      idx = t < 2 ? 63 : t < 4 ? 0 : $urandom_range(59);
      threeWireSelect = t == 3 || (t > 3 && 1'($urandom));
      wd = $urandom;
      u_srs_master_model.frame({dir, step, idx[5:0]}, nb, wd, rd);
      for (int k = 0; k < nb; k++)
        if (!dir) shadow[addr_of(idx, step, k)] = wd[31 - 8 * k -: 8];
        else `CHK(rd[8 * (nb - 1 - k) +: 8], shadow[addr_of(idx, step, k)])
      foreach (mem[i]) `CHK(mem[i], shadow[i])
      $display("test %0d done", t);
    end
    close_out();
  end
endmodule // spi_register_access_slave_test
